// >>> bench/spsam_core_asserts.sv
// Port-level assertions for the address match core.
`timescale 1ns/10ps
`include "spsam_consts.vh"
module spsam_core_asserts (
  input wire        ref_clk,
  input wire        reset,
  input wire        wb_cyc,
  input wire        wb_stb,
  input wire        wb_we,
  input wire [7:0]  wb_adr,
  input wire [3:0]  wb_sel,
  input wire [31:0] wb_dat_w,
  input wire [31:0] wb_dat_r,
  input wire        wb_ack,
  input wire        scl_in,
  input wire        scl_out,
  input wire        scl_oe,
  input wire        sda_in,
  input wire        sda_out,
  input wire        sda_oe,
  input wire        irq
);
  reg  [2:0] wr_cnt;
  reg        mask_dirty;
  wire       taken = wb_cyc && wb_stb && !wb_ack;
  wire       wr_ack = wb_ack && wb_we;
  // Counts down after every accepted write, which may release the hold.
  always @(posedge ref_clk) begin
    if (reset) begin
      wr_cnt     <= 3'h0;
      mask_dirty <= 1'b0;
    end else begin
      wr_cnt <= (taken && wb_we) ? 3'h4 :
                (wr_cnt != 3'h0) ? wr_cnt - 3'h1 : 3'h0;
      if (taken && wb_we && wb_sel[0] && wb_adr == `SPSAM_OFS_MASK)
        mask_dirty <= 1'b1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_taken;
    wb_cyc && wb_stb && !wb_ack;
  endsequence
  sequence s_mask_read;
    wb_ack && !$past(wb_we) && $past(wb_adr) == `SPSAM_OFS_MASK;
  endsequence
  chk_ack_latency: assert property (s_taken |=> wb_ack)
    else $error("Bus ack late");
  chk_ack_pulse: assert property (wb_ack |=> !wb_ack)
    else $error("Bus ack longer than one cycle");
  chk_rdata_idle: assert property (!wb_ack |-> wb_dat_r == 32'h0)
    else $error("Read data not zero outside ack");
  chk_mask_reset: assert property (s_mask_read ##0 !mask_dirty
    |-> wb_dat_r[7:0] == `SPSAM_MASK_RST)
    else $error("Mask not all ones before first write");
  chk_hold_stands: assert property (
    scl_oe && wr_cnt == 3'h0 && !(taken && wb_we) |=> scl_oe)
    else $error("Clock hold dropped without a write");
  chk_release_cause: assert property (
    $fell(scl_oe) |-> wr_cnt != 3'h0)
    else $error("Clock released without a write");
  chk_hold_on_low: assert property (
    $rose(scl_oe) |-> !scl_in && !$past(scl_in, 2))
    else $error("Clock hold began while clock high");
  chk_irq_clear: assert property (
    $fell(irq) |-> $past(wr_ack) || $past(wr_ack, 2))
    else $error("Interrupt fell without a write");
  chk_open_drain: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("Pin driven high");
endmodule // spsam_core_asserts

bind spsam_core spsam_core_asserts u_chk (
  .ref_clk(ref_clk), .reset(reset), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
  .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
  .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq)
);

// >>> bench/spsam_core_tb.sv
// Self-checking bench: register tasks and a two-wire bus master.
`timescale 1ns/10ps
`include "spsam_consts.vh"
module spsam_core_tb;
  reg         ref_clk;
  reg         reset;
  reg         wb_cyc;
  reg         wb_stb;
  reg         wb_we;
  reg  [7:0]  wb_adr;
  reg  [3:0]  wb_sel;
  reg  [31:0] wb_dat_w;
  wire [31:0] wb_dat_r;
  wire        wb_ack, scl_out, scl_oe, sda_out, sda_oe, irq;
  wire        m_scl_low, m_sda_low;
  wire        scl_line = !(scl_oe && !scl_out) && !m_scl_low;
  wire        sda_line = !(sda_oe && !sda_out) && !m_sda_low;
  integer     err_total, n_compared;
  reg         acked;
  reg  [7:0]  q;
  reg  [7:0]  rxb;

  spsam_core u_dut (
    .ref_clk(ref_clk), .reset(reset), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .scl_in(scl_line),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
  spsam_i2c_master u_mst (
    .ref_clk(ref_clk), .scl_line(scl_line), .sda_line(sda_line),
    .scl_low(m_scl_low), .sda_low(m_sda_low));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task results;
    begin
      err_total = err_total + u_mst.n_stuck;
      $display("Compared %0d errors %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task cmp8(input [7:0] got, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("ERROR t=%0t byte %h not %h", $time, got, exp);
      end
    end
  endtask
  task cmp1(input got, input exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("ERROR t=%0t bit %b not %b", $time, got, exp);
      end
    end
  endtask
  // One classic Wishbone cycle; read data lands in q.
  task bus(input [7:0] adr, input we, input [7:0] d);
    integer n;
    begin
      wb_cyc   <= 1'b1;
      wb_stb   <= 1'b1;
      wb_we    <= we;
      wb_adr   <= adr;
      wb_sel   <= 4'h1;
      wb_dat_w <= {24'h0, d};
      n = 0;
      @(posedge ref_clk);
      while (wb_ack !== 1'b1 && n < 50) begin
        @(posedge ref_clk);
        n = n + 1;
      end
      q = wb_dat_r[7:0];
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we  <= 1'b0;
      wb_sel <= 4'h0;
      if (n >= 50) begin
        err_total = err_total + 1;
        $display("ERROR t=%0t no bus ack", $time);
        results;
      end
      @(posedge ref_clk);
    end
  endtask
  task rd(input [7:0] adr, input [7:0] m, input [7:0] e);
    begin
      bus(adr, 1'b0, 8'h00);
      cmp8(q & m, e);
    end
  endtask
  task wr(input [7:0] adr, input [7:0] d);
    bus(adr, 1'b1, d);
  endtask
  task bt(input [7:0] b, input e);
    begin
      u_mst.send8(b);
      u_mst.ack9(acked);
      cmp1(acked, e);
    end
  endtask

  initial begin
    reset = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat_w = 32'h0;
    err_total = 0;
    n_compared = 0;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rd(`SPSAM_OFS_MASK, 8'hff, 8'hff);
    rd(8'h24, 8'hff, 8'h00);
    wr(`SPSAM_OFS_ADDR, 8'h5a);
    wr(`SPSAM_OFS_IMASK, 8'h03);
    wr(`SPSAM_OFS_CTRL2, 8'h01);
    u_mst.start;
    bt(8'h5a, 1'b1);
    cmp1(irq, 1'b1);
    rd(`SPSAM_OFS_STAT, 8'h01, 8'h01);
    rd(`SPSAM_OFS_BUF, 8'hff, 8'h5a);
    rd(`SPSAM_OFS_STAT, 8'h01, 8'h00);
    bt(8'hc3, 1'b1);
    rd(`SPSAM_OFS_BUF, 8'hff, 8'hc3);
    u_mst.stop;
    wr(`SPSAM_OFS_IMASK, 8'h00);
    cmp1(irq, 1'b0);
    wr(`SPSAM_OFS_IMASK, 8'h03);
    cmp1(irq, 1'b1);
    wr(`SPSAM_OFS_ISTAT, 8'h03);
    cmp1(irq, 1'b0);
    wr(`SPSAM_OFS_MASK, 8'hf0);
    u_mst.start;
    bt(8'h54, 1'b1);
    u_mst.stop;
    u_mst.start;
    bt(8'h7a, 1'b0);
    u_mst.stop;
    rd(`SPSAM_OFS_BUF, 8'hff, 8'h54);
    wr(`SPSAM_OFS_MASK, 8'hff);
    u_mst.start;
    bt(8'h00, 1'b0);
    u_mst.stop;
    wr(`SPSAM_OFS_CTRL2, 8'h81);
    u_mst.start;
    bt(8'h00, 1'b1);
    rd(`SPSAM_OFS_ISTAT, 8'h02, 8'h02);
    rd(`SPSAM_OFS_BUF, 8'hff, 8'h00);
    bt(8'ha5, 1'b1);
    rd(`SPSAM_OFS_BUF, 8'hff, 8'ha5);
    u_mst.stop;
    wr(`SPSAM_OFS_CTRL2, 8'h83);
    wr(`SPSAM_OFS_ADDRHI, 8'h02);
    wr(`SPSAM_OFS_ADDR, 8'h34);
    wr(`SPSAM_OFS_MASK, 8'h00);
    u_mst.start;
    bt(8'h00, 1'b1);
    rd(`SPSAM_OFS_STAT, 8'h22, 8'h00);
    rd(`SPSAM_OFS_BUF, 8'hff, 8'h00);
    bt(8'h3c, 1'b1);
    rd(`SPSAM_OFS_STAT, 8'h20, 8'h20);
    rd(`SPSAM_OFS_BUF, 8'hff, 8'h3c);
    u_mst.stop;
    u_mst.start;
    bt(8'hf6, 1'b0);
    u_mst.stop;
    u_mst.start;
    bt(8'hf4, 1'b1);
    bt(8'hc7, 1'b1);
    rd(`SPSAM_OFS_STAT, 8'h02, 8'h02);
    u_mst.stop;
    rd(`SPSAM_OFS_BUF, 8'hff, 8'hf4);
    wr(`SPSAM_OFS_CTRL2, 8'h81);
    wr(`SPSAM_OFS_CTRL3, 8'h02);
    u_mst.start;
    u_mst.send8(8'h00);
    cmp1(scl_oe, 1'b1);
    rd(`SPSAM_OFS_STAT, 8'h40, 8'h40);
    wr(`SPSAM_OFS_CTRL2, 8'ha1);
    wr(`SPSAM_OFS_CTRL3, 8'h12);
    u_mst.ack9(acked);
    cmp1(acked, 1'b0);
    u_mst.stop;
    wr(`SPSAM_OFS_CTRL3, 8'h00);
    wr(`SPSAM_OFS_MASK, 8'hff);
    rd(`SPSAM_OFS_BUF, 8'hff, 8'h00);
    wr(`SPSAM_OFS_BUF, 8'h96);
    u_mst.start;
    bt(8'h35, 1'b1);
    wr(`SPSAM_OFS_ISTAT, 8'h03);
    cmp1(irq, 1'b0);
    u_mst.recv8(rxb);
    cmp8(rxb, 8'h96);
    u_mst.ack9(acked);
    cmp1(irq, 1'b1);
    u_mst.stop;
    results;
  end
endmodule // spsam_core_tb

// >>> bench/spsam_i2c_master.sv
// Behavioural two-wire bus master for the far side of the core.
`timescale 1ns/10ps
module spsam_i2c_master (
  input  wire ref_clk,
  input  wire scl_line,
  input  wire sda_line,
  output reg  scl_low,
  output reg  sda_low
);
  integer n_stuck;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    n_stuck = 0;
  end
  task wt(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Releases SCL and waits, boundedly, while the slave stretches it.
  task rise;
    integer k;
    begin
      scl_low <= 1'b0;
      k = 0;
      @(posedge ref_clk);
      while (scl_line !== 1'b1 && k < 3000) begin
        @(posedge ref_clk);
        k = k + 1;
      end
      if (k >= 3000) begin
        n_stuck = n_stuck + 1;
        $display("ERROR t=%0t clock held too long", $time);
      end
    end
  endtask
  task start;
    begin
      sda_low <= 1'b1;
      wt(8);
      scl_low <= 1'b1;
      wt(4);
    end
  endtask
  task send8(input [7:0] b);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        sda_low <= ~b[i];
        wt(4);
        rise;
        wt(7);
        scl_low <= 1'b1;
        wt(4);
      end
      wt(4);
    end
  endtask
  task ack9(output a);
    begin
      sda_low <= 1'b0;
      wt(4);
      rise;
      wt(4);
      a = !sda_line;
      wt(4);
      scl_low <= 1'b1;
      wt(4);
    end
  endtask
  // Reads one byte from the slave, MSB first, sampling in the high phase.
  task recv8(output [7:0] b);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        sda_low <= 1'b0;
        wt(4);
        rise;
        wt(4);
        b[i] = sda_line;
        wt(3);
        scl_low <= 1'b1;
        wt(4);
      end
      wt(4);
    end
  endtask
  task stop;
    begin
      sda_low <= 1'b1;
      wt(4);
      rise;
      wt(8);
      sda_low <= 1'b0;
      wt(8);
    end
  endtask
endmodule // spsam_i2c_master

// >>> design/spsam_core.v
// Two-wire slave address match unit with a classic Wishbone slave.
//
// Behaviour
// RULE_01 - General call enabled: acknowledge address zero always (code: with address hold on, a set ACKDV bit NACKs it)
// RULE_02 - All-zero write address raises the interrupt
// RULE_03 - General call never sets update address flag
// RULE_04 - Byte after general call is data
// RULE_05 - Address hold stretches SCL after eighth fall
// RULE_06 - Software sets ack value, then releases clock
// RULE_07 - Zero mask bit ignores that address bit
// RULE_08 - Mask register resets to all ones
// RULE_09 - Seven-bit mode masks address bits 7..1
// RULE_10 - Ten-bit mode masks low byte only
// RULE_11 - Received byte loaded sets buffer full
// RULE_12 - Reading the buffer clears buffer full
// RULE_13 - Shift register reachable only through buffer
// RULE_14 - Software reads buffer before writing next
// RULE_15 - Completed transfer raises the interrupt
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
`include "spsam_consts.vh"
module spsam_core (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire        wb_cyc,
  input  wire        wb_stb,
  input  wire        wb_we,
  input  wire [7:0]  wb_adr,
  input  wire [3:0]  wb_sel,
  input  wire [31:0] wb_dat_w,
  output reg  [31:0] wb_dat_r,
  output reg         wb_ack,
  input  wire        scl_in,
  output reg         scl_out,
  output reg         scl_oe,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  output reg         irq
);
  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_RX   = 5'h02;
  localparam [4:0] ST_ACK  = 5'h04;
  localparam [4:0] ST_TX   = 5'h08;
  localparam [4:0] ST_TACK = 5'h10;

  // --------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // --------------------------------------------------------------------
  wire scl_s;
  wire sda_s;
  reg  scl_q;
  reg  sda_q;

  spsam_sync u_scl_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .din     (scl_in),
    .dout    (scl_s)
  );

  spsam_sync u_sda_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .din     (sda_in),
    .dout    (sda_s)
  );

  always @(posedge ref_clk) begin
    if (reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  wire scl_rise  = scl_s & ~scl_q;
  wire scl_fall  = ~scl_s & scl_q;
  wire bus_start = scl_s & scl_q & sda_q & ~sda_s;
  wire bus_stop  = scl_s & scl_q & ~sda_q & sda_s;

  // --------------------------------------------------------------------
  // Registers and bus strobes
  // --------------------------------------------------------------------
  reg [7:0] transfer_buffer;
  reg [7:0] tx_data;
  reg [7:0] serial_shift_reg;
  reg [7:0] own_address_reg;
  reg [1:0] own_address_high;
  reg [7:0] address_mask_reg;
  reg [7:0] port_control_reg_2;
  reg       address_hold_enable;
  reg [1:0] irq_status;
  reg [1:0] irq_mask;
  reg       buffer_full_flag;
  reg       update_address_flag;
  reg       read_write;
  reg       data_not_address;
  reg       clock_held;
  reg       gcall_seen;

  reg [4:0] state;
  reg [3:0] bit_count;
  reg       addr_first;
  reg       addr_low;
  reg       ten_matched;
  reg       ack_given;
  reg       go_tx;
  reg       master_ack;

  wire acc    = wb_cyc & wb_stb & ~wb_ack;
  wire bus_wr = acc & wb_we & wb_sel[0];
  wire bus_rd = acc & ~wb_we;
  wire enable = port_control_reg_2[`SPSAM_C2_EN];
  wire ten    = port_control_reg_2[`SPSAM_C2_TEN];
  wire gce    = port_control_reg_2[`SPSAM_C2_GCE];
  wire ackdv  = port_control_reg_2[`SPSAM_C2_ACKDV];
  wire release_wr = bus_wr & (wb_adr == `SPSAM_OFS_CTRL3) &
                    wb_dat_w[`SPSAM_C3_REL];

  // --------------------------------------------------------------------
  // Address comparison
  // --------------------------------------------------------------------
  wire [7:0] diff  = serial_shift_reg ^ own_address_reg;
  wire gc_hit  = gce & (serial_shift_reg == `SPSAM_GC_ADDR); // see RULE_01
  wire m7_hit  = ((diff & address_mask_reg & `SPSAM_RW_IGNORE) ==
                  `SPSAM_ZERO8); // see RULE_07 see RULE_09
  wire hi_hit  = (serial_shift_reg[7:3] == `SPSAM_TEN_PFX) &
                 (serial_shift_reg[2:1] == own_address_high); // see RULE_10
  wire lo_hit  = ((diff & address_mask_reg) == `SPSAM_ZERO8); // see RULE_10
  wire byte_in = (state == ST_RX) & scl_fall &
                 (bit_count == `SPSAM_BYTE_BITS);

  reg next_match;
  reg next_tx;
  reg next_is_addr;
  always @* begin
    next_match   = 1'b0;
    next_tx      = 1'b0;
    next_is_addr = 1'b1;
    if (addr_first) begin
      if (gc_hit) begin
        next_match = 1'b1;
      end else if (!ten) begin
        next_match = m7_hit;
        next_tx    = serial_shift_reg[0];
      end else if (hi_hit) begin
        next_match = ~serial_shift_reg[0] | ten_matched;
        next_tx    = serial_shift_reg[0];
      end
    end else if (addr_low) begin
      next_match = lo_hit;
    end else begin
      next_is_addr = 1'b0;
      next_match   = 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Slave engine and register writes
  // --------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (reset) begin
      transfer_buffer     <= `SPSAM_ZERO8;
      tx_data             <= `SPSAM_ZERO8;
      serial_shift_reg    <= `SPSAM_ZERO8;
      own_address_reg     <= `SPSAM_ZERO8;
      own_address_high    <= 2'h0;
      address_mask_reg    <= `SPSAM_MASK_RST; // see RULE_08
      port_control_reg_2  <= `SPSAM_ZERO8;
      address_hold_enable <= 1'b0;
      irq_status          <= 2'h0;
      irq_mask            <= 2'h0;
      buffer_full_flag    <= 1'b0;
      update_address_flag <= 1'b0;
      read_write          <= 1'b0;
      data_not_address    <= 1'b0;
      clock_held          <= 1'b0;
      gcall_seen          <= 1'b0;
      state               <= ST_IDLE;
      bit_count           <= 4'h0;
      addr_first          <= 1'b0;
      addr_low            <= 1'b0;
      ten_matched         <= 1'b0;
      ack_given           <= 1'b0;
      go_tx               <= 1'b0;
      master_ack          <= 1'b0;
      scl_out             <= 1'b0;
      scl_oe              <= 1'b0;
      sda_out             <= 1'b0;
      sda_oe              <= 1'b0;
      irq                 <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
      // Clears by software come first so that a same-cycle set wins.
      if (bus_rd && wb_adr == `SPSAM_OFS_BUF) begin
        buffer_full_flag <= 1'b0; // see RULE_12
      end
      if (bus_wr) begin
        case (wb_adr)
          `SPSAM_OFS_BUF:    tx_data <= wb_dat_w[7:0]; // see RULE_13
          `SPSAM_OFS_CTRL2:  port_control_reg_2 <= wb_dat_w[7:0];
          `SPSAM_OFS_CTRL3: begin
            address_hold_enable <= wb_dat_w[`SPSAM_C3_AHOLD];
          end
          `SPSAM_OFS_ADDR: begin
            own_address_reg     <= wb_dat_w[7:0];
            update_address_flag <= 1'b0;
          end
          `SPSAM_OFS_ADDRHI: own_address_high <= wb_dat_w[1:0];
          `SPSAM_OFS_MASK:   address_mask_reg <= wb_dat_w[7:0];
          `SPSAM_OFS_ISTAT:  irq_status <= irq_status & ~wb_dat_w[1:0];
          `SPSAM_OFS_IMASK:  irq_mask <= wb_dat_w[1:0];
          default: begin
          end
        endcase
      end

      case (state)
        ST_IDLE: begin
          sda_oe <= 1'b0;
        end
        ST_RX: begin
          if (scl_rise) begin
            serial_shift_reg <= {serial_shift_reg[6:0], sda_s};
            bit_count        <= bit_count + `SPSAM_BIT_ONE;
          end
          if (byte_in) begin
            if (!next_match) begin
              state <= ST_IDLE;
            end else begin
              state            <= ST_ACK;
              data_not_address <= ~next_is_addr;
              irq_status[`SPSAM_IRQ_DONE] <= 1'b1; // see RULE_15
              if (!buffer_full_flag) begin
                transfer_buffer  <= serial_shift_reg;
                buffer_full_flag <= 1'b1; // see RULE_11
              end
              ack_given <= next_is_addr | ~buffer_full_flag;
              if (addr_first) begin
                read_write <= serial_shift_reg[0];
                go_tx      <= next_tx;
                gcall_seen <= gc_hit;
                if (gc_hit) begin
                  irq_status[`SPSAM_IRQ_GCALL] <= 1'b1; // see RULE_02
                end
                // General call skips the low byte. see RULE_03 see RULE_04
                addr_low   <= ten & ~gc_hit & ~serial_shift_reg[0];
                if (ten & ~gc_hit) begin
                  update_address_flag <= 1'b1;
                end
              end else if (addr_low) begin
                update_address_flag <= 1'b1;
                ten_matched         <= 1'b1;
                addr_low            <= 1'b0;
              end
              addr_first <= 1'b0;
              if (next_is_addr && address_hold_enable) begin
                clock_held <= 1'b1;
                scl_oe     <= 1'b1; // see RULE_05
              end else begin
                sda_oe <= next_is_addr | ~buffer_full_flag;
              end
            end
          end
        end
        ST_ACK: begin
          if (clock_held) begin
            if (release_wr) begin
              clock_held <= 1'b0;
              scl_oe     <= 1'b0;
              sda_oe     <= ~ackdv; // see RULE_06
              ack_given  <= ~ackdv;
            end
          end else if (scl_fall) begin
            bit_count <= 4'h0;
            if (!ack_given) begin
              sda_oe <= 1'b0;
              state  <= ST_IDLE;
            end else if (go_tx) begin
              serial_shift_reg <= tx_data; // see RULE_13
              sda_oe           <= ~tx_data[7];
              state            <= ST_TX;
            end else begin
              sda_oe <= 1'b0;
              state  <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            bit_count        <= bit_count + `SPSAM_BIT_ONE;
            serial_shift_reg <= {serial_shift_reg[6:0], 1'b0};
            if (bit_count == `SPSAM_LAST_TX) begin
              sda_oe <= 1'b0;
              state  <= ST_TACK;
            end else begin
              sda_oe <= ~serial_shift_reg[6];
            end
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            master_ack <= ~sda_s;
            irq_status[`SPSAM_IRQ_DONE] <= 1'b1; // see RULE_15
          end
          if (scl_fall) begin
            bit_count <= 4'h0;
            if (master_ack) begin
              serial_shift_reg <= tx_data;
              sda_oe           <= ~tx_data[7];
              state            <= ST_TX;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase

      if (!enable || bus_stop) begin
        state       <= ST_IDLE;
        ten_matched <= 1'b0;
        clock_held  <= 1'b0;
        scl_oe      <= 1'b0;
        sda_oe      <= 1'b0;
      end else if (bus_start) begin
        state      <= ST_RX;
        bit_count  <= 4'h0;
        addr_first <= 1'b1;
        addr_low   <= 1'b0;
        clock_held <= 1'b0;
        scl_oe     <= 1'b0;
        sda_oe     <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Wishbone answer
  // --------------------------------------------------------------------
  reg [7:0] rd_mux;
  always @* begin
    rd_mux = `SPSAM_ZERO8;
    case (wb_adr)
      `SPSAM_OFS_BUF:    rd_mux = transfer_buffer;
      `SPSAM_OFS_STAT:   rd_mux = {1'b0, clock_held, data_not_address,
                                   gcall_seen, 1'b0, read_write,
                                   update_address_flag,
                                   buffer_full_flag};
      `SPSAM_OFS_CTRL2:  rd_mux = port_control_reg_2;
      `SPSAM_OFS_CTRL3:  rd_mux = {6'h00, address_hold_enable, 1'b0};
      `SPSAM_OFS_ADDR:   rd_mux = own_address_reg;
      `SPSAM_OFS_ADDRHI: rd_mux = {6'h00, own_address_high};
      `SPSAM_OFS_MASK:   rd_mux = address_mask_reg;
      `SPSAM_OFS_ISTAT:  rd_mux = {6'h00, irq_status};
      `SPSAM_OFS_IMASK:  rd_mux = {6'h00, irq_mask};
      default:           rd_mux = `SPSAM_ZERO8;
    endcase
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      wb_ack   <= 1'b0;
      wb_dat_r <= 32'h00000000;
    end else begin
      wb_ack   <= acc;
      wb_dat_r <= acc ? {24'h000000, rd_mux} : 32'h00000000;
    end
  end
endmodule // spsam_core

// >>> design/spsam_sync.v
// Two-flop synchroniser for one level from outside the clock domain.
`timescale 1ns/10ps
module spsam_sync (
  input  wire ref_clk,
  input  wire reset,
  input  wire din,
  output reg  dout
);
  reg meta;

  always @(posedge ref_clk) begin
    if (reset) begin
      meta <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // spsam_sync

// >>> pkg/spsam_consts.vh
// Constants of the serial port slave address match block.
`ifndef SPSAM_CONSTS_VH
`define SPSAM_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SPSAM_OFS_BUF    8'h00
`define SPSAM_OFS_STAT   8'h04
`define SPSAM_OFS_CTRL2  8'h08
`define SPSAM_OFS_CTRL3  8'h0c
`define SPSAM_OFS_ADDR   8'h10
`define SPSAM_OFS_ADDRHI 8'h14
`define SPSAM_OFS_MASK   8'h18
`define SPSAM_OFS_ISTAT  8'h1c
`define SPSAM_OFS_IMASK  8'h20

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SPSAM_C2_EN      0
`define SPSAM_C2_TEN     1
`define SPSAM_C2_ACKDV   5
`define SPSAM_C2_GCE     7
`define SPSAM_C3_AHOLD   1
`define SPSAM_C3_REL     4
`define SPSAM_IRQ_DONE   0
`define SPSAM_IRQ_GCALL  1

// ----------------------------------------------------------------------
// Reset values and address codes
// ----------------------------------------------------------------------
`define SPSAM_MASK_RST   8'hff
`define SPSAM_ZERO8      8'h00
`define SPSAM_GC_ADDR    8'h00
`define SPSAM_RW_IGNORE  8'hfe
`define SPSAM_TEN_PFX    5'h1e
`define SPSAM_BYTE_BITS  4'h8
`define SPSAM_LAST_TX    4'h7
`define SPSAM_BIT_ONE    4'h1

`endif
